// ### core/slider_velocity_and_recal.sv
/*
  Slider speed logic: extra interrupts after fast slides, speed scaled
  repeat interrupts, and forced digital recalibration requests.
  Assumes the serial management decoder presents a simple byte register
  port on sys_clk, and that slider and touch inputs come from logic on
  the same clock.
*/
// Summary of operation
// (RQ1) enable bit 7 allows extra interrupts after a fast slide; clear stops them
// (RQ2) extra interrupt count grows with slide speed, never above the maximum
// (RQ3) bits 6-4 set maximum extra interrupts 0..7, reset value 100b
// (RQ4) below half window M, to three quarters M/2, to full window M>=4
// (RQ5) bits 3-2 give longest slide earning extras; longer slides earn none
// (RQ6) slide window codes decode to 350, 560, 770, 980 ms; 01 at reset
// (RQ7) speed is distinct slider sensors touched per 100 ms, with scale bits 1-0
// (RQ8) repeat rate table by sensor count and scale; one sensor uses base rate
// (RQ9) scale 11 uses 140, 105, 70 ms for two, three, four sensors
// (RQ10) request bit rebuilds a channel base count from scratch and replaces it
// (RQ11) request bits clear themselves when recalibration ends; reset to zero
// (RQ12) bit 7 recalibrates grouped slider, bits 6..0 channels seven..one
// (RQ13) extra and repeat interrupts share the touch interrupt output with touch events; sources in the same cycle give one pulse
`timescale 1ns/1ps
`include "slider_speed_consts.svh"

module slider_velocity_and_recal
  import slider_speed_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic       sys_clk,               // system clock, 125 MHz
  input  wire logic       rst,                   // synchronous reset, high
  input  wire logic [7:0] regAddr,               // register address
  input  wire logic [7:0] regWrData,             // write data
  input  wire logic       regWrEn,               // one-cycle write strobe
  output logic      [7:0] regRdData,             // read data, one cycle late
  input  wire logic [6:0] sensorTouch,           // grouped slider sensor touch levels
  input  wire logic       slideActive,           // high while a slide is in progress
  input  wire logic [3:0] sliderBaseRepeatRate,  // base rate, (code+1)*35 ms
  input  wire logic       touchEvent,            // ordinary touch interrupt pulse
  output logic            touchIrq,              // shared interrupt pulse
  input  wire logic [7:0] recalDone,             // engine finished, per request bit
  output logic            groupRecalRequest,     // grouped slider recalibration
  output logic      [6:0] chanRecalRequest,      // channels seven..one
  output logic            groupBaseReload,       // replace grouped base count
  output logic      [6:0] chanBaseReload         // replace channel base count
);

  recal_if rif ();

  logic         msTick;
  speed_state_t s_r;
  speed_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // count of set bits among seven sensors
  function automatic logic [2:0] popCount7(input logic [6:0] v);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < 7; i++) begin
      c = c + {2'h0, v[i]};
    end
    return c;
  endfunction

  // slide window length from the configuration code
  function automatic logic [9:0] slideWindow(input logic [1:0] code);
    logic [9:0] w;
    case (code)                                                     // RQ6
      2'h0:    w = `SLIDE_WIN0_MS;
      2'h1:    w = `SLIDE_WIN1_MS;
      2'h2:    w = `SLIDE_WIN2_MS;
      2'h3:    w = `SLIDE_WIN3_MS;
      default: w = `SLIDE_WIN1_MS;
    endcase
    return w;
  endfunction

  // number of extra interrupts for a finished slide
  function automatic logic [2:0] extraCount(input logic [2:0] maxInt,
                                            input logic [9:0] t,
                                            input logic [9:0] w);
    logic [2:0]  k;
    logic [11:0] t4;
    logic [11:0] w2;
    logic [11:0] w3;
    t4 = {t, 2'b00};
    w2 = {1'b0, w, 1'b0};
    w3 = {1'b0, w, 1'b0} + {2'h0, w};
    if (t4 < w2) begin
      k = maxInt;                                                   // RQ4
    end else if (t4 < w3) begin
      k = {1'b0, maxInt[2:1]};                                      // RQ4
    end else if (t <= w) begin
      k = {2'h0, maxInt[2]};                                        // RQ4
    end else begin
      k = 3'h0;                                                     // RQ5
    end
    return k;
  endfunction

  // repeat period from speed and scale
  function automatic logic [9:0] repeatPeriod(input logic [2:0] n,
                                              input logic [1:0] scale,
                                              input logic [9:0] baseMs);
    logic [9:0] r;
    r = `RATE_35_MS;
    if (n >= 3'h5) begin
      r = `RATE_35_MS;                                              // RQ8
    end else if (n == 3'h4) begin
      r = (scale == 2'h3) ? `RATE_70_MS : `RATE_35_MS;              // RQ9
    end else if (n == 3'h3) begin
      case (scale)                                                  // RQ8
        2'h3:    r = `RATE_105_MS;                                  // RQ9
        2'h2:    r = `RATE_70_MS;
        default: r = `RATE_35_MS;
      endcase
    end else if (n == 3'h2) begin
      case (scale)                                                  // RQ8
        2'h3:    r = `RATE_140_MS;                                  // RQ9
        2'h2:    r = `RATE_105_MS;
        2'h1:    r = `RATE_70_MS;
        default: r = `RATE_35_MS;
      endcase
    end else begin
      r = baseMs;                                                   // RQ8
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // submodules

  // millisecond time base
  ms_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tick    (msTick)
  );

  // recalibration request bits
  recal_seq u_recal (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .recalDone (recalDone),
    .bus       (rif.seq)
  );

  // software sets request bits by writing ones
  assign rif.setMask = (regWrEn && regAddr == `RECAL_REQ_ADDR) ? regWrData : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [6:0] seenNow;
  logic [9:0] baseMs;
  logic [9:0] rateMs;
  logic [9:0] gapInc;
  logic [9:0] slideInc;
  logic [2:0] extraNow;
  logic       accelEn;

  // derived values for the next state
  always_comb begin
    accelEn = s_r.cfg[`CFG_ACCEL_EN_BIT];
    seenNow = s_r.seenMask | (sensorTouch & ~s_r.prevTouch);       // RQ7
    baseMs = 10'(({6'h00, sliderBaseRepeatRate} + 10'h001) * `RATE_35_MS);
    // speed scaling is an extra interrupt source, so the enable gates it
    rateMs = accelEn
           ? repeatPeriod(s_r.speedCount, s_r.cfg[`CFG_SCALE_HI:`CFG_SCALE_LO], baseMs)
           : baseMs;                                                // RQ7
    gapInc = s_r.gapMs + 10'h001;
    slideInc = (s_r.slideMs == `SLIDE_MS_MAX) ? s_r.slideMs : s_r.slideMs + 10'h001;
    extraNow = extraCount(s_r.cfg[`CFG_MAX_HI:`CFG_MAX_LO], s_r.slideMs,
                          slideWindow(s_r.cfg[`CFG_SLIDE_HI:`CFG_SLIDE_LO]));  // RQ2
  end

  // speed window, slide tracking, interrupts and registers
  always_comb begin
    s_nxt = s_r;
    s_nxt.irq = touchEvent;                                         // RQ13
    s_nxt.prevTouch = sensorTouch;
    s_nxt.seenMask = seenNow;

    // distinct sensors touched per 100 ms window
    if (msTick) begin
      if (s_r.winMs == `SPEED_WINDOW_MS - 7'h01) begin
        s_nxt.winMs = 7'h00;
        s_nxt.speedCount = popCount7(seenNow);                      // RQ7
        s_nxt.seenMask = 7'h00;
      end else begin
        s_nxt.winMs = s_r.winMs + 7'h01;
      end
    end

    case (s_r.phase)
      SLIDE_IDLE: begin
        if (slideActive) begin
          s_nxt.phase = SLIDE_RUN;
          s_nxt.slideMs = 10'h000;
          s_nxt.gapMs = 10'h000;
        end
      end
      SLIDE_RUN: begin
        if (msTick) begin
          s_nxt.slideMs = slideInc;
          if (gapInc >= rateMs) begin
            s_nxt.irq = 1'b1;                                       // RQ13
            s_nxt.gapMs = 10'h000;
          end else begin
            s_nxt.gapMs = gapInc;
          end
        end
        if (!slideActive) begin
          s_nxt.gapMs = 10'h000;
          if (accelEn && extraNow != 3'h0) begin                    // RQ1
            s_nxt.phase = SLIDE_EXTRA;
            s_nxt.extraLeft = extraNow;                             // RQ3
          end else begin
            s_nxt.phase = SLIDE_IDLE;
          end
        end
      end
      SLIDE_EXTRA: begin
        if (slideActive) begin
          // a new slide drops the remaining extras
          s_nxt.phase = SLIDE_RUN;
          s_nxt.slideMs = 10'h000;
          s_nxt.gapMs = 10'h000;
          s_nxt.extraLeft = 3'h0;
        end else if (!accelEn) begin
          s_nxt.phase = SLIDE_IDLE;                                 // RQ1
          s_nxt.extraLeft = 3'h0;
        end else if (msTick) begin
          if (gapInc >= `EXTRA_GAP_MS) begin
            s_nxt.irq = 1'b1;                                       // RQ13
            s_nxt.gapMs = 10'h000;
            s_nxt.extraLeft = s_r.extraLeft - 3'h1;                 // RQ2
            if (s_r.extraLeft == 3'h1) begin
              s_nxt.phase = SLIDE_IDLE;
            end
          end else begin
            s_nxt.gapMs = gapInc;
          end
        end
      end
      default: begin
        s_nxt.phase = SLIDE_IDLE;
      end
    endcase

    // configuration write
    if (regWrEn && regAddr == `SPEED_CFG_ADDR) begin
      s_nxt.cfg = regWrData;                                        // RQ3
    end

    // registered read data
    case (regAddr)
      `SPEED_CFG_ADDR: s_nxt.rdData = s_r.cfg;
      `RECAL_REQ_ADDR: s_nxt.rdData = rif.pending;                  // RQ11
      default:         s_nxt.rdData = `UNMAPPED_READ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.cfg <= `SPEED_CFG_RESET;                                  // RQ3
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign regRdData = s_r.rdData;
  assign touchIrq = s_r.irq;                                        // RQ13
  assign groupRecalRequest = rif.pending[`RECAL_GROUP_BIT];         // RQ12
  assign chanRecalRequest = rif.pending[`RECAL_CHAN_HI:`RECAL_CHAN_LO];  // RQ12
  assign groupBaseReload = rif.reload[`RECAL_GROUP_BIT];            // RQ10
  assign chanBaseReload = rif.reload[`RECAL_CHAN_HI:`RECAL_CHAN_LO];     // RQ10

endmodule

// ### core/slider_speed_consts.svh
/*
  Offsets, field positions, reset values and timing counts for the slider
  speed and forced recalibration block.
  Assumes a 125 MHz system clock and millisecond based slide timing.
*/
`ifndef SLIDER_SPEED_CONSTS_SVH
`define SLIDER_SPEED_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets and reset values
`define SPEED_CFG_ADDR     8'h3e
`define RECAL_REQ_ADDR     8'h3f
`define SPEED_CFG_RESET    8'hc5
`define RECAL_REQ_RESET    8'h00
`define UNMAPPED_READ      8'h00

////////////////////////////////////////////////////////////////////////////////
// field positions of the speed configuration register
`define CFG_ACCEL_EN_BIT   7
`define CFG_MAX_HI         6
`define CFG_MAX_LO         4
`define CFG_SLIDE_HI       3
`define CFG_SLIDE_LO       2
`define CFG_SCALE_HI       1
`define CFG_SCALE_LO       0

// field positions of the recalibration request register
`define RECAL_GROUP_BIT    7
`define RECAL_CHAN_HI      6
`define RECAL_CHAN_LO      0

////////////////////////////////////////////////////////////////////////////////
// timing
`define SYS_CLK_HZ         125000000
`define TICK_MS            1
`define TICK_CYCLES        (`SYS_CLK_HZ / 1000 * `TICK_MS)
`define SPEED_WINDOW_MS    7'd100
`define SLIDE_WIN0_MS      10'd350
`define SLIDE_WIN1_MS      10'd560
`define SLIDE_WIN2_MS      10'd770
`define SLIDE_WIN3_MS      10'd980
`define RATE_35_MS         10'd35
`define RATE_70_MS         10'd70
`define RATE_105_MS        10'd105
`define RATE_140_MS        10'd140
`define EXTRA_GAP_MS       10'd35
`define SLIDE_MS_MAX       10'h3ff

`endif

// ### core/slider_speed_pkg.sv
/*
  Types shared by the slider speed block and its recalibration sequencer.
  Assumes the constants header is included where numbers are needed.
*/
package slider_speed_pkg;

  // slide tracking phases
  typedef enum logic [1:0] {
    SLIDE_IDLE,
    SLIDE_RUN,
    SLIDE_EXTRA
  } slide_state_t;

  // whole state of the speed logic
  typedef struct packed {
    logic [7:0]   cfg;
    slide_state_t phase;
    logic [6:0]   prevTouch;
    logic [6:0]   seenMask;
    logic [6:0]   winMs;
    logic [2:0]   speedCount;
    logic [9:0]   slideMs;
    logic [9:0]   gapMs;
    logic [2:0]   extraLeft;
    logic         irq;
    logic [7:0]   rdData;
  } speed_state_t;

  // whole state of the recalibration sequencer
  typedef struct packed {
    logic [7:0] pending;
    logic [7:0] reload;
  } recal_state_t;

endpackage

// ### core/recal_if.sv
/*
  Carrier between the speed core and the recalibration sequencer.
  Assumes both ends share sys_clk.
*/
`timescale 1ns/1ps

interface recal_if;
  logic [7:0] setMask;   // one-cycle set request per channel
  logic [7:0] pending;   // requests still running
  logic [7:0] reload;    // one-cycle base count replace strobe

  modport core (output setMask, input pending, input reload);
  modport seq  (input setMask, output pending, output reload);
endinterface

// ### core/ms_tick.sv
/*
  Millisecond tick generator.
  Assumes a free running clock; the period is a parameter so that
  simulation can shorten it.
*/
`timescale 1ns/1ps
`include "slider_speed_consts.svh"

module ms_tick
  import slider_speed_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic sys_clk,   // system clock
  input  wire logic rst,       // synchronous reset
  output logic      tick       // one-cycle pulse per period
);

  typedef struct packed {
    logic [16:0] count;
    logic        tick;
  } tick_state_t;

  tick_state_t s_r;
  tick_state_t s_nxt;

  // count the period up to a pulse
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.count == 17'(TICK_CYCLES - 1)) begin
      s_nxt.count = 17'h00000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.count = s_r.count + 17'h00001;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

// ### core/recal_seq.sv
/*
  Forced recalibration request bits with self clearing on completion.
  Assumes the calibration engine pulses a done bit only for a channel
  it was asked to rebuild.
*/
`timescale 1ns/1ps
`include "slider_speed_consts.svh"

module recal_seq
  import slider_speed_pkg::*;
(
  input  wire logic       sys_clk,   // system clock
  input  wire logic       rst,       // synchronous reset
  input  wire logic [7:0] recalDone, // engine finished, per channel
  recal_if.seq            bus        // set, pending, reload
);

  recal_state_t s_r;
  recal_state_t s_nxt;

  // set wins over the completion clear in the same cycle
  always_comb begin
    s_nxt = s_r;
    s_nxt.reload = recalDone & s_r.pending;                         // RQ10
    s_nxt.pending = (s_r.pending & ~recalDone) | bus.setMask;      // RQ11
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.pending <= `RECAL_REQ_RESET;                             // RQ11
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.pending = s_r.pending;
  assign bus.reload = s_r.reload;
endmodule

// ### bench/slider_speed_properties.sv
/*
  port checker for the slider speed and recalibration block.
  assumes it is bound onto the top module and shares its clock and reset.
*/
`timescale 1ns/1ps

module slider_speed_properties #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic       sys_clk,           // system clock
  input wire logic       rst,               // synchronous reset
  input wire logic [7:0] regAddr,           // register address
  input wire logic [7:0] regWrData,         // write data
  input wire logic       regWrEn,           // write strobe
  input wire logic [7:0] regRdData,         // read data
  input wire logic       touchEvent,        // ordinary touch pulse
  input wire logic       touchIrq,          // shared interrupt
  input wire logic [7:0] recalDone,         // engine done
  input wire logic       groupRecalRequest, // group request
  input wire logic [6:0] chanRecalRequest,  // channel requests
  input wire logic       groupBaseReload,   // group reload strobe
  input wire logic [6:0] chanBaseReload     // channel reload strobes
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [7:0] req;

  // request bits in register order
  assign req = {groupRecalRequest, chanRecalRequest};

  ////////////////////////////////////////////////////////////////////////////
  // register port
  property p_cfg_readback;
    logic [7:0] v;
    (regWrEn && regAddr == 8'h3e, v = regWrData) ##1 regAddr == 8'h3e |=> regRdData == v;
  endproperty
  a_cfg_readback: assert property (p_cfg_readback) else $error("cfg readback wrong");

  property p_recal_set;
    regWrEn && regAddr == 8'h3f |=> (req & $past(regWrData)) == $past(regWrData);
  endproperty
  a_recal_set: assert property (p_recal_set) else $error("request bit not set");

  ////////////////////////////////////////////////////////////////////////////
  // recalibration completion
  property p_write_no_clear;
    req[1] && !recalDone[1] |=> req[1];
  endproperty
  a_write_no_clear: assert property (p_write_no_clear) else $error("bit lost early");

  property p_chan_clear;
    recalDone[0] && req[0] && !(regWrEn && regAddr == 8'h3f && regWrData[0])
      |=> !req[0] && chanBaseReload[0];
  endproperty
  a_chan_clear: assert property (p_chan_clear) else $error("channel not cleared");

  property p_group_clear;
    recalDone[7] && req[7] && !(regWrEn && regAddr == 8'h3f && regWrData[7])
      |=> !groupRecalRequest && groupBaseReload;
  endproperty
  a_group_clear: assert property (p_group_clear) else $error("group not cleared");

  property p_reload_cause;
    chanBaseReload[0] |-> $past(recalDone[0]) && $past(chanRecalRequest[0]);
  endproperty
  a_reload_cause: assert property (p_reload_cause) else $error("reload without done");

  property p_reload_pulse;
    groupBaseReload |=> !groupBaseReload;
  endproperty
  a_reload_pulse: assert property (p_reload_pulse) else $error("reload too long");

  ////////////////////////////////////////////////////////////////////////////
  // interrupt path
  property p_event_pass;
    touchEvent |=> touchIrq;
  endproperty
  a_event_pass: assert property (p_event_pass) else $error("touch not passed");

  c_cfg_write: cover property (regWrEn && regAddr == 8'h3e);
  c_recal_done: cover property (chanBaseReload[0]);
  c_event: cover property (touchEvent ##1 touchIrq);
endmodule

bind slider_velocity_and_recal slider_speed_properties #(.TICK_CYCLES(TICK_CYCLES)) props_i (
  .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdData(regRdData), .touchEvent(touchEvent), .touchIrq(touchIrq),
  .recalDone(recalDone), .groupRecalRequest(groupRecalRequest),
  .chanRecalRequest(chanRecalRequest), .groupBaseReload(groupBaseReload),
  .chanBaseReload(chanBaseReload));

// ### bench/cal_engine_model.sv
/*
  calibration engine model: rebuilds a base count per request bit.
  assumes request levels from the block; each bit takes longer than the last.
*/
`timescale 1ns/1ps

module cal_engine_model #(
  parameter int unsigned BASE_DELAY = 12
) (
  input  wire logic       sys_clk, // system clock
  input  wire logic       rst,     // synchronous reset
  input  wire logic [7:0] req,     // request levels
  output logic      [7:0] done     // one-cycle done per bit
);
  int cnt [8];

  // count while requested, pulse done once the rebuild time is spent
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 8; i++) begin
      done[i] <= !rst && req[i] && cnt[i] == int'(BASE_DELAY) + 4 * i;
      if (rst || !req[i]) begin
        cnt[i] <= 0;
      end else if (cnt[i] == int'(BASE_DELAY) + 4 * i) begin
        cnt[i]  <= 0;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule

// ### bench/slider_velocity_and_recal_tb_top.sv
/*
  testbench for the slider speed and recalibration block.
  assumes a shortened ms tick; inputs change on the falling edge.
*/
`timescale 1ns/1ps

module slider_velocity_and_recal_tb_top;
  localparam int unsigned TICK = 4;

  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic       regWrEn = 1'b0;
  logic [6:0] sensorTouch = 7'h00;
  logic       slideActive = 1'b0;
  logic [3:0] sliderBaseRepeatRate = 4'hf;
  logic       touchEvent = 1'b0;
  logic [7:0] regRdData;
  logic [7:0] recalDone;
  logic       touchIrq;
  logic       groupRecalRequest;
  logic       groupBaseReload;
  logic [6:0] chanRecalRequest;
  logic [6:0] chanBaseReload;
  int         err_count = 0;
  int         check_count = 0;

  // 125 MHz
  always #4 sys_clk = ~sys_clk;

  slider_velocity_and_recal #(.TICK_CYCLES(TICK)) slider_velocity_and_recal_i (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdData(regRdData), .sensorTouch(sensorTouch),
    .slideActive(slideActive), .sliderBaseRepeatRate(sliderBaseRepeatRate),
    .touchEvent(touchEvent), .touchIrq(touchIrq), .recalDone(recalDone),
    .groupRecalRequest(groupRecalRequest), .chanRecalRequest(chanRecalRequest),
    .groupBaseReload(groupBaseReload), .chanBaseReload(chanBaseReload));

  cal_engine_model cal_engine_model_i (
    .sys_clk(sys_clk), .rst(rst), .req({groupRecalRequest, chanRecalRequest}),
    .done(recalDone));

  ////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkn(string n, int e, int g);
    check_count++;
    if (g != e) begin
      err_count++;
      $display("[ERR] %s expected %0d seen %0d", n, e, g);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // register port, entered at a falling edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge sys_clk);
    regWrEn = 1'b0;
    @(negedge sys_clk); // an edge passes before the next strobe
  endtask

  task automatic rd(logic [7:0] a, output logic [7:0] d);
    regAddr = a;
    @(negedge sys_clk);
    d = regRdData;
  endtask

  // slide of t ms, then count interrupts after it ends
  task automatic slide(int t, output int n);
    n = 0;
    slideActive = 1'b1;
    repeat (t * TICK) @(negedge sys_clk);
    slideActive = 1'b0;
    repeat (300 * TICK) begin
      @(negedge sys_clk);
      if (touchIrq === 1'b1) n++;
    end
  endtask

  // long slide touching pat every 100 ms; spacing of the last two interrupts
  task automatic rpt(logic [6:0] pat, output int sp);
    int last;
    int prev;
    last = 0;
    prev = 0;
    slideActive = 1'b1;
    for (int c = 0; c < 800 * TICK; c++) begin
      sensorTouch = ((c / (50 * TICK)) % 2) ? pat : 7'h00;
      @(negedge sys_clk);
      if (touchIrq === 1'b1) begin
        prev = last;
        last = c;
      end
    end
    slideActive = 1'b0;
    sensorTouch = 7'h00;
    sp = last - prev;
    repeat (300 * TICK) @(negedge sys_clk);
  endtask

  // extras for max m, slide t ms, window w ms
  function automatic int exp_extra(int m, int t, int w, bit en);
    if (!en) return 0;
    if (4 * t < 2 * w) return m;
    if (4 * t < 3 * w) return m >> 1;
    if (t <= w) return (m >= 4) ? 1 : 0;
    return 0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] acc;
    int n;
    int w;
    int ms [4] = '{7, 4, 3, 1};
    int ts [4] = '{100, 200, 300, 400};
    int tw [3] = '{500, 700, 900};
    logic [6:0] pat [7] = '{7'h03, 7'h03, 7'h03, 7'h03, 7'h0f, 7'h1f, 7'h01};
    int sc [7] = '{0, 1, 2, 3, 3, 0, 0};
    int re [7] = '{35, 70, 105, 140, 70, 35, 70};
    logic [7:0] mk [2] = '{8'h81, 8'h7e};
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    rd(8'h3e, d); chk8("cfg_reset", 8'hc5, d);
    rd(8'h3f, d); chk8("recal_reset", 8'h00, d);
    wr(8'h40, 8'hff);
    rd(8'h40, d); chk8("unmapped", 8'h00, d);
    rd(8'h3e, d); chk8("cfg_kept", 8'hc5, d);
    wr(8'h3e, 8'h5a);
    rd(8'h3e, d); chk8("cfg_rw", 8'h5a, d);
    touchEvent = 1'b1;
    @(negedge sys_clk);
    touchEvent = 1'b0;
    n = (touchIrq === 1'b1) ? 1 : 0;
    chkn("touch_irq", 1, n);
    // extra interrupts by max and slide band, shortest window
    foreach (ms[i]) begin
      foreach (ts[j]) begin
        wr(8'h3e, {1'b1, 3'(ms[i]), 2'b00, 2'b01});
        slide(ts[j], n);
        chkn("extras", exp_extra(ms[i], ts[j], 350, 1'b1), n);
      end
    end
    // longer window codes still earn one extra
    for (int c = 1; c < 4; c++) begin
      wr(8'h3e, {1'b1, 3'd4, 2'(c), 2'b01});
      slide(tw[c - 1], n);
      chkn("window", 1, n);
    end
    wr(8'h3e, {1'b0, 3'd7, 2'b00, 2'b01});
    slide(100, n);
    chkn("disabled", 0, n);
    // repeat rate by sensors touched and scale, base rate 70 ms
    sliderBaseRepeatRate = 4'h1;
    foreach (pat[i]) begin
      wr(8'h3e, {1'b1, 3'd0, 2'b00, 2'(sc[i])});
      rpt(pat[i], n);
      chkn("repeat", re[i] * int'(TICK), n);
    end
    // enable clear drops speed scaling back to the base rate
    wr(8'h3e, {1'b0, 3'd0, 2'b00, 2'b00});
    rpt(7'h1f, n);
    chkn("repeat_off", 70 * int'(TICK), n);
    // forced recalibration, write of zero must not clear
    foreach (mk[i]) begin
      wr(8'h3f, mk[i]);
      chk8("recal_set", mk[i], {groupRecalRequest, chanRecalRequest});
      wr(8'h3f, 8'h00);
      rd(8'h3f, d); chk8("recal_hold", mk[i], d);
      acc = 8'h00;
      for (w = 0; w < 200; w++) begin
        @(negedge sys_clk);
        acc = acc | {groupBaseReload, chanBaseReload};
        if ({groupRecalRequest, chanRecalRequest} === 8'h00) break;
      end
      if (w == 200) begin
        err_count++;
        $display("[ERR] recal_wait expected clear seen timeout");
        final_report();
      end
      chk8("reload", mk[i], acc);
      rd(8'h3f, d); chk8("recal_clear", 8'h00, d);
    end
    final_report();
  end
endmodule
